/* File: core/fall_edge_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module fall_edge_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] pin_in,
  output var  logic [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] sync1;
  logic [WIDTH-1:0] sync2;
  logic [WIDTH-1:0] prev;

  initial begin
    if (WIDTH < 1) $error("fall_edge_sync: WIDTH must be at least 1");
  end

  // Idle-high pins: reset to one so release gives no false edge
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sync1 <= '1;
      sync2 <= '1;
      prev  <= '1;
      fall  <= '0;
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
      prev  <= sync2;
      fall  <= prev & ~sync2;
    end
  end

endmodule : fall_edge_sync
`default_nettype wire

/* File: core/timer2_core.sv */
`timescale 1ns/10ps
`default_nettype none
module timer2_core #(
  parameter int ADDR_W = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              nrst,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output var  logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output var  logic              wready,
  output var  logic [1:0]        bresp,
  output var  logic              bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output var  logic              arready,
  output var  logic [31:0]       rdata,
  output var  logic [1:0]        rresp,
  output var  logic              rvalid,
  input  wire logic              rready,
  input  wire logic              trigger_pin,
  input  wire logic              count_input_pin,
  input  wire logic              timer1_overflow,
  input  wire logic [1:0]        serial_mode,
  output var  logic              rx_baud_tick,
  output var  logic              tx_baud_tick,
  output var  logic              irq
);

  initial begin
    if (ADDR_W < 8) $error("timer2_core: ADDR_W must be at least 8");
  end

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[8*i +: 8] = nw[8*i +: 8];
    end
    return res;
  endfunction : merge

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    return {a[7:2], 2'b00} == off;
  endfunction : hit

  timer2_pkg::ctrl_s ctrl;
  logic [15:0]       reload;
  logic [15:0]       count;
  logic [1:0]        irq_status;
  logic [1:0]        irq_enable;

  // Pin edges
  logic [1:0] pin_fall;
  fall_edge_sync #(
    .WIDTH (2)
  ) u_pins (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .pin_in  ({count_input_pin, trigger_pin}),
    .fall    (pin_fall)
  );
  wire trig_fall  = pin_fall[0];
  wire count_fall = pin_fall[1];

  // Write channel
  logic              aw_have;
  logic              w_have;
  logic [ADDR_W-1:0] waddr;
  logic [31:0]       wdat;
  logic [3:0]        wstb;

  wire aw_fire       = awvalid & awready;
  wire w_fire        = wvalid & wready;
  wire do_write      = aw_have & w_have & ~bvalid;
  wire next_aw_have  = (aw_have | aw_fire) & ~do_write;
  wire next_w_have   = (w_have | w_fire) & ~do_write;

  wire sel_ctrl      = hit(waddr, timer2_pkg::OFF_CTRL);
  wire sel_reload    = hit(waddr, timer2_pkg::OFF_RELOAD);
  wire sel_count     = hit(waddr, timer2_pkg::OFF_COUNT);
  wire sel_bit       = hit(waddr, timer2_pkg::OFF_CTRL_BIT);
  wire sel_status    = hit(waddr, timer2_pkg::OFF_IRQ_STATUS);
  wire sel_clear     = hit(waddr, timer2_pkg::OFF_IRQ_CLEAR);
  wire sel_enable    = hit(waddr, timer2_pkg::OFF_IRQ_ENABLE);
  wire w_mapped      = sel_ctrl | sel_reload | sel_count | sel_bit | sel_status
                       | sel_clear | sel_enable;

  wire ctrl_byte_wr  = do_write & sel_ctrl & wstb[0];
  wire bit_wr        = do_write & sel_bit & wstb[0];
  wire ctrl_wr       = ctrl_byte_wr | bit_wr;
  wire reload_wr     = do_write & sel_reload & (|wstb[1:0]);
  wire count_wr      = do_write & sel_count & (|wstb[1:0]);
  wire clear_wr      = do_write & sel_clear & wstb[0];
  wire enable_wr     = do_write & sel_enable & wstb[0];

  wire [31:0] reload_merged = merge({16'h0000, reload}, wdat, wstb);
  wire [31:0] count_merged  = merge({16'h0000, count}, wdat, wstb);
  localparam int BIT_W = timer2_pkg::BIT_IDX_W;
  wire [BIT_W-1:0] bit_idx  = wdat[timer2_pkg::BIT_IDX_LSB +: BIT_W];

  // Timer datapath
  wire baud_use    = ctrl.rx_baud_source_select | ctrl.tx_baud_source_select;
  wire count_src   = ctrl.count_source_select ? count_fall : 1'b1;
  wire inc         = ctrl.run_control & count_src;
  wire ovf         = inc & (count == timer2_pkg::COUNT_MAX);
  wire trig        = ctrl.trigger_enable & trig_fall & ~baud_use;
  wire auto_reload = baud_use | ~ctrl.capture_reload_select;
  wire capture     = trig & ~auto_reload;
  wire ovf_set     = ovf & ~baud_use;
  wire ext_set     = trig;
  wire baud_mode   = serial_mode[0];
  wire rx_src      = ctrl.rx_baud_source_select ? ovf : timer1_overflow;
  wire tx_src      = ctrl.tx_baud_source_select ? ovf : timer1_overflow;

  logic [15:0] next_count;
  always_comb begin
    next_count = count;
    if (count_wr) next_count = count_merged[15:0];
    else if (ovf) next_count = auto_reload ? reload : 16'h0000;
    else if (trig & auto_reload) next_count = reload;
    else if (inc) next_count = count + 16'h0001;
  end

  // Software write first, then hardware sets win over any clear
  timer2_pkg::ctrl_s next_ctrl;
  always_comb begin
    next_ctrl = ctrl;
    if (ctrl_byte_wr) next_ctrl = timer2_pkg::ctrl_s'(wdat[7:0]);
    if (bit_wr) next_ctrl[bit_idx] = wdat[timer2_pkg::BIT_VAL_POS];
    if (ovf_set) next_ctrl.overflow_flag = 1'b1;
    if (ext_set) next_ctrl.external_event_flag = 1'b1;
  end

  wire [1:0] irq_events = {ext_set, ovf_set};
  wire [1:0] next_irq_status = (irq_status & ~(clear_wr ? wdat[1:0] : 2'h0)) | irq_events;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl       <= timer2_pkg::ctrl_s'(timer2_pkg::CTRL_RESET);
      count      <= timer2_pkg::COUNT_RESET;
      reload     <= timer2_pkg::RELOAD_RESET;
      irq_status <= timer2_pkg::IRQ_RESET;
      irq_enable <= timer2_pkg::IRQ_RESET;
    end else begin
      ctrl       <= next_ctrl;
      count      <= next_count;
      if (reload_wr) reload <= reload_merged[15:0];
      else if (capture) reload <= count;
      irq_status <= next_irq_status;
      if (enable_wr) irq_enable <= wdat[1:0];
    end
  end

  // Baud ticks and interrupt, all registered
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rx_baud_tick <= 1'b0;
      tx_baud_tick <= 1'b0;
      irq          <= 1'b0;
    end else begin
      rx_baud_tick <= baud_mode & rx_src;
      tx_baud_tick <= baud_mode & tx_src;
      irq          <= |(irq_status & irq_enable);
    end
  end

  // Write handshake; address and data taken in either order
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      aw_have <= 1'b0;
      w_have  <= 1'b0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= timer2_pkg::RESP_OKAY;
      waddr   <= '0;
      wdat    <= 32'h0000_0000;
      wstb    <= 4'h0;
    end else begin
      aw_have <= next_aw_have;
      w_have  <= next_w_have;
      awready <= ~next_aw_have;
      wready  <= ~next_w_have;
      if (aw_fire) waddr <= awaddr;
      if (w_fire) begin
        wdat <= wdata;
        wstb <= wstrb;
      end
      if (do_write) begin
        bvalid <= 1'b1;
        bresp  <= w_mapped ? timer2_pkg::RESP_OKAY : timer2_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read path; the clear register is write-only and reads zero
  wire ar_fire = arvalid & arready;
  wire r_ctrl  = hit(araddr, timer2_pkg::OFF_CTRL);
  wire r_rel   = hit(araddr, timer2_pkg::OFF_RELOAD);
  wire r_cnt   = hit(araddr, timer2_pkg::OFF_COUNT);
  wire r_bit   = hit(araddr, timer2_pkg::OFF_CTRL_BIT);
  wire r_stat  = hit(araddr, timer2_pkg::OFF_IRQ_STATUS);
  wire r_clr   = hit(araddr, timer2_pkg::OFF_IRQ_CLEAR);
  wire r_en    = hit(araddr, timer2_pkg::OFF_IRQ_ENABLE);
  wire r_mapped = r_ctrl | r_rel | r_cnt | r_bit | r_stat | r_clr | r_en;
  wire [31:0] read_word = r_ctrl ? {24'h000000, ctrl} :
                          r_rel  ? {16'h0000, reload} :
                          r_cnt  ? {16'h0000, count} :
                          r_stat ? {30'h0, irq_status} :
                          r_en   ? {30'h0, irq_enable} : 32'h0000_0000;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= timer2_pkg::RESP_OKAY;
    end else begin
      arready <= ~(ar_fire | (rvalid & ~rready));
      if (ar_fire) begin
        rvalid <= 1'b1;
        rdata  <= read_word;
        rresp  <= r_mapped ? timer2_pkg::RESP_OKAY : timer2_pkg::RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  chk_ovf_flag_set: assert property (
    ovf_set |=> ctrl.overflow_flag)
    else $error("overflow flag not set on overflow");

  chk_ovf_flag_baud: assert property (
    (ovf && baud_use && !ctrl.overflow_flag && !ctrl_wr) |=> !ctrl.overflow_flag)
    else $error("overflow flag set while clocking serial port");

  chk_ext_flag_set: assert property (
    trig |=> ctrl.external_event_flag)
    else $error("event flag not set on trigger");

  chk_ext_irq: assert property (
    (trig && irq_enable[timer2_pkg::IRQ_EXT_POS] && !enable_wr && !clear_wr) |=> ##1 irq)
    else $error("event flag did not raise interrupt");

  chk_ext_sticky: assert property (
    (ctrl.external_event_flag && !ctrl_wr) |=> ctrl.external_event_flag)
    else $error("event flag cleared by hardware");

  chk_rx_source: assert property (
    (baud_mode && (ctrl.rx_baud_source_select ? ovf : timer1_overflow)) |=> rx_baud_tick)
    else $error("receive baud tick missing");

  chk_tx_source: assert property (
    (!baud_mode || !(ctrl.tx_baud_source_select ? ovf : timer1_overflow)) |=> !tx_baud_tick)
    else $error("spurious transmit baud tick");

  chk_trig_baud: assert property (
    (trig_fall && baud_use && !ctrl.external_event_flag && !ctrl_wr)
      |=> !ctrl.external_event_flag)
    else $error("trigger acted while clocking serial port");

  chk_stop_hold: assert property (
    (!ctrl.run_control && !count_wr && !trig) |=> count == $past(count))
    else $error("timer moved while stopped");

  chk_timer_inc: assert property (
    (ctrl.run_control && !ctrl.count_source_select && !ovf && !trig && !count_wr)
      |=> count == $past(count) + 16'h0001)
    else $error("timer mode did not increment");

  chk_pin_wait: assert property (
    (ctrl.run_control && ctrl.count_source_select && !count_fall && !trig && !count_wr)
      |=> count == $past(count))
    else $error("counter moved without pin edge");

  chk_forced_reload: assert property (
    (ovf && baud_use && !count_wr) |=> count == $past(reload))
    else $error("baud use did not reload on overflow");

  chk_trig_reload: assert property (
    (trig && !ctrl.capture_reload_select && !count_wr) |=> count == $past(reload))
    else $error("trigger did not reload");

  chk_capture_val: assert property (
    (capture && !reload_wr) |=> reload == $past(count))
    else $error("capture value wrong");

  cov_overflow: cover property (ovf_set ##1 irq_status[timer2_pkg::IRQ_OVF_POS]);
  cov_capture:  cover property (capture);
  cov_baud:     cover property (ovf && baud_use ##1 rx_baud_tick);
  cov_set_clr:  cover property (ovf_set && clear_wr);

endmodule : timer2_core
`default_nettype wire

/* File: core/timer2_pkg.sv */
package timer2_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL       = 8'hc8;
  localparam logic [7:0] OFF_RELOAD     = 8'hcc;
  localparam logic [7:0] OFF_COUNT      = 8'hd0;
  localparam logic [7:0] OFF_CTRL_BIT   = 8'hd4;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'hd8;
  localparam logic [7:0] OFF_IRQ_CLEAR  = 8'hdc;
  localparam logic [7:0] OFF_IRQ_ENABLE = 8'he0;

  // Reset values
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [15:0] RELOAD_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET  = 16'h0000;
  localparam logic [1:0]  IRQ_RESET    = 2'h0;

  // Single-bit access word: bit index in [2:0], value in [3]
  localparam int BIT_IDX_LSB = 0;
  localparam int BIT_IDX_W   = 3;
  localparam int BIT_VAL_POS = 3;

  // Interrupt status, clear and enable layout
  localparam int IRQ_OVF_POS = 0;
  localparam int IRQ_EXT_POS = 1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [15:0] COUNT_MAX = 16'hffff;

  typedef struct packed {
    logic overflow_flag;
    logic external_event_flag;
    logic rx_baud_source_select;
    logic tx_baud_source_select;
    logic trigger_enable;
    logic run_control;
    logic count_source_select;
    logic capture_reload_select;
  } ctrl_s;

endpackage : timer2_pkg

/* File: verif/pin_partner.sv */
`timescale 1ns/10ps
`default_nettype none
module pin_partner (
  input  wire logic       sys_clk,
  input  wire logic       rx_baud_tick,
  input  wire logic       tx_baud_tick,
  output var  logic       trigger_pin,
  output var  logic       count_input_pin,
  output var  logic       timer1_overflow,
  output var  logic [1:0] serial_mode
);
  int rx_n = 0;
  int tx_n = 0;
  // Pins rest high like pulled-up lines, so idle never looks like an edge
  initial begin
    trigger_pin = 1'b1;
    count_input_pin = 1'b1;
    timer1_overflow = 1'b0;
    serial_mode = 2'h1;
  end
  always @(posedge sys_clk) begin
    if (rx_baud_tick === 1'b1) rx_n <= rx_n + 1;
    if (tx_baud_tick === 1'b1) tx_n <= tx_n + 1;
  end
  // Low for four cycles: longer than the synchroniser needs to see it
  task pin_fall(input bit trig);
    @(posedge sys_clk);
    if (trig) trigger_pin <= 1'b0;
    else count_input_pin <= 1'b0;
    repeat (4) @(posedge sys_clk);
    trigger_pin <= 1'b1;
    count_input_pin <= 1'b1;
    repeat (4) @(posedge sys_clk);
  endtask : pin_fall
  task set_mode(input logic [1:0] m);
    @(posedge sys_clk);
    serial_mode <= m;
  endtask : set_mode
  task t1_pulse;
    @(posedge sys_clk);
    timer1_overflow <= 1'b1;
    @(posedge sys_clk);
    timer1_overflow <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : t1_pulse
endmodule : pin_partner
`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        sys_clk = 1'b0;
  logic        nrst    = 1'b0;
  logic [7:0]  awaddr  = 8'h00;
  logic [7:0]  araddr  = 8'h00;
  logic [31:0] wdata   = 32'h0;
  logic [3:0]  wstrb   = 4'hf;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, rx_tick, tx_tick, irq;
  logic        trig, cnt_pin, t1_ovf;
  logic [1:0]  bresp, rresp, smode;
  logic [31:0] rdata, rd;
  logic [1:0]  rsp, wresp;
  int          bad_count = 0;
  int          n_checks = 0;
  always #4 sys_clk = ~sys_clk;
  timer2_core dut (.sys_clk(sys_clk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .trigger_pin(trig), .count_input_pin(cnt_pin), .timer1_overflow(t1_ovf),
    .serial_mode(smode), .rx_baud_tick(rx_tick), .tx_baud_tick(tx_tick), .irq(irq));
  pin_partner partner (.sys_clk(sys_clk), .rx_baud_tick(rx_tick), .tx_baud_tick(tx_tick),
    .trigger_pin(trig), .count_input_pin(cnt_pin), .timer1_overflow(t1_ovf),
    .serial_mode(smode));
  task chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task chk_bit(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask : chk_bit
  // Address and data go out together; each is dropped once taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        bready <= 1'b0;
        wresp = bresp;
      end
    end while (!(bready && bvalid));
  endtask : wr
  task rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask : rd_reg
  task rd_chk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
    logic [1:0] r;
    rd_reg(a, rd, r);
    chk_val(rd & mask, exp);
  endtask : rd_chk
  task test_reset;
    logic [1:0] r;
    rd_chk(timer2_pkg::OFF_CTRL, 32'hffffffff, 32'h0);
    rd_reg(8'hf0, rd, r);
    chk_val({30'h0, r}, {30'h0, timer2_pkg::RESP_SLVERR});
    wr(8'hf0, 32'h0);
    chk_val({30'h0, wresp}, {30'h0, timer2_pkg::RESP_SLVERR});
    wr(timer2_pkg::OFF_IRQ_ENABLE, 32'h0);
    chk_val({30'h0, wresp}, {30'h0, timer2_pkg::RESP_OKAY});
    $display("test reset done");
  endtask : test_reset
  task test_bit_write;
    wr(timer2_pkg::OFF_CTRL_BIT, 32'h0000000d);
    rd_chk(timer2_pkg::OFF_CTRL, 32'hff, 32'h20);
    wr(timer2_pkg::OFF_CTRL_BIT, 32'h00000005);
    rd_chk(timer2_pkg::OFF_CTRL, 32'hff, 32'h00);
    $display("test bit_write done");
  endtask : test_bit_write
  task test_overflow;
    wr(timer2_pkg::OFF_RELOAD, 32'h1234);
    wr(timer2_pkg::OFF_COUNT, 32'hfff0);
    wr(timer2_pkg::OFF_CTRL, 32'h04);
    repeat (40) @(posedge sys_clk);
    rd_chk(timer2_pkg::OFF_CTRL, 32'h80, 32'h80);
    wr(timer2_pkg::OFF_CTRL, 32'h80);
    rd_reg(timer2_pkg::OFF_COUNT, rd, rsp);
    chk_bit(rd[15:0] >= 16'h1234 && rd[15:0] < 16'h1300, 1'b1);
    rd_chk(timer2_pkg::OFF_COUNT, 32'hffff, rd);
    rd_chk(timer2_pkg::OFF_IRQ_STATUS, 32'h3, 32'h1);
    chk_bit(irq, 1'b0);
    wr(timer2_pkg::OFF_IRQ_ENABLE, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk_bit(irq, 1'b1);
    wr(timer2_pkg::OFF_IRQ_CLEAR, 32'h1);
    wr(timer2_pkg::OFF_CTRL, 32'h00);
    repeat (2) @(posedge sys_clk);
    chk_bit(irq, 1'b0);
    $display("test overflow done");
  endtask : test_overflow
  task test_trigger;
    wr(timer2_pkg::OFF_CTRL, 32'h04);
    partner.pin_fall(1'b1);
    rd_chk(timer2_pkg::OFF_CTRL, 32'h40, 32'h00);
    wr(timer2_pkg::OFF_RELOAD, 32'h0);
    wr(timer2_pkg::OFF_COUNT, 32'h0100);
    wr(timer2_pkg::OFF_CTRL, 32'h0d);
    partner.pin_fall(1'b1);
    rd_chk(timer2_pkg::OFF_CTRL, 32'h40, 32'h40);
    rd_reg(timer2_pkg::OFF_RELOAD, rd, rsp);
    chk_bit(rd[15:0] > 16'h0100 && rd[15:0] < 16'h0140, 1'b1);
    wr(timer2_pkg::OFF_IRQ_ENABLE, 32'h2);
    repeat (2) @(posedge sys_clk);
    chk_bit(irq, 1'b1);
    wr(timer2_pkg::OFF_CTRL, 32'h00);
    wr(timer2_pkg::OFF_IRQ_CLEAR, 32'h3);
    $display("test trigger done");
  endtask : test_trigger
  task test_counter;
    wr(timer2_pkg::OFF_COUNT, 32'h0);
    wr(timer2_pkg::OFF_CTRL, 32'h06);
    repeat (3) partner.pin_fall(1'b0);
    wr(timer2_pkg::OFF_CTRL, 32'h00);
    rd_chk(timer2_pkg::OFF_COUNT, 32'hffff, 32'h3);
    $display("test counter done");
  endtask : test_counter
  // Both flags stay clear and the trigger pin is ignored while the timer feeds the serial port
  task test_baud;
    int tx_base;
    wr(timer2_pkg::OFF_RELOAD, 32'hfff0);
    wr(timer2_pkg::OFF_COUNT, 32'hfff0);
    wr(timer2_pkg::OFF_CTRL, 32'h3d);
    partner.pin_fall(1'b1);
    repeat (60) @(posedge sys_clk);
    chk_bit(partner.rx_n > 2 && partner.tx_n > 2, 1'b1);
    rd_chk(timer2_pkg::OFF_CTRL, 32'hc0, 32'h00);
    rd_reg(timer2_pkg::OFF_COUNT, rd, rsp);
    chk_bit(rd[15:0] >= 16'hfff0, 1'b1);
    wr(timer2_pkg::OFF_CTRL, 32'h24);
    repeat (4) @(posedge sys_clk);
    tx_base = partner.tx_n;
    repeat (3) partner.t1_pulse();
    chk_val(partner.tx_n - tx_base, 32'd3);
    partner.set_mode(2'h0);
    tx_base = partner.tx_n;
    repeat (2) partner.t1_pulse();
    chk_val(partner.tx_n - tx_base, 32'd0);
    partner.set_mode(2'h1);
    wr(timer2_pkg::OFF_CTRL, 32'h00);
    $display("test baud done");
  endtask : test_baud
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    test_reset();
    test_bit_write();
    test_overflow();
    test_trigger();
    test_counter();
    test_baud();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
